// >>> common/pac_cfg.svh
`ifndef PAC_CFG_SVH
`define PAC_CFG_SVH

// ------------------------------------------------------------------
// register indices (implied holding-register numbers)
// ------------------------------------------------------------------
`define PAC_IDX_AO_LAST    8'h07
`define PAC_IDX_ACC_FIRST  8'h08
`define PAC_IDX_SAVE_CD    8'h0C
`define PAC_IDX_FREQ_BASE  8'h0D
`define PAC_IDX_FREQ_EXP   8'h08
`define PAC_IDX_LAST_BASE  8'h0E
`define PAC_IDX_LAST_EXP   8'h09

// ------------------------------------------------------------------
// field layout and reset values
// ------------------------------------------------------------------
`define PAC_DEC_MAX        14'h270F
`define PAC_SAVE_SECONDS   9'h12C
`define PAC_FREQ_MAX       16'hFFFF
`define PAC_ACC_RST        14'h0000
`define PAC_AO_RST         16'h0000

// ------------------------------------------------------------------
// timing
// ------------------------------------------------------------------
`define PAC_SEC_NS         1000000000
`define PAC_CLK_NS         40
`define PAC_SEC_CYCLES     (`PAC_SEC_NS / `PAC_CLK_NS)

`endif

// >>> common/pac_pkg.sv
package pac_pkg;

    typedef logic [13:0] pac_dec_t;
    typedef logic [15:0] pac_word_t;

    typedef enum logic [1:0] {
        PAC_RSP_IDLE,
        PAC_RSP_ACK,
        PAC_RSP_ERR
    } pac_rsp_t;

endpackage

// >>> rtl/pac_counter.sv
// The Wishbone interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "pac_cfg.svh"
`default_nettype none

module pac_counter #(
    parameter bit IS_BASE    = 1'b1,
    parameter int SEC_CYCLES = `PAC_SEC_CYCLES
) (
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    input  wire logic [9:0]             adr_i,
    input  wire logic [31:0]            dat_i,
    input  wire logic [3:0]             sel_i,
    input  wire logic                   we_i,
    input  wire logic                   cyc_i,
    input  wire logic                   stb_i,
    output logic      [31:0]            dat_o,
    output logic                        ack_o,
    output logic                        err_o,
    input  wire logic [1:0]             cnt_in_i,
    output logic      [7:0][15:0]       ao_data_o,
    output logic                        save_o,
    output logic      [1:0][13:0]       saved_hi_o,
    output logic      [1:0][13:0]       saved_lo_o
);

    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------
    function automatic pac_pkg::pac_word_t pac_merge(
        input pac_pkg::pac_word_t old_v,
        input logic [31:0]        dat,
        input logic [3:0]         sel
    );
        pac_pkg::pac_word_t r;
        r = old_v;
        if (sel[0]) begin
            r[7:0] = dat[7:0];
        end
        if (sel[1]) begin
            r[15:8] = dat[15:8];
        end
        return r;
    endfunction

    // preset values above the decimal span are held at 9999
    function automatic pac_pkg::pac_dec_t pac_clamp(
        input pac_pkg::pac_word_t v
    );
        pac_pkg::pac_dec_t r;
        r = `PAC_DEC_MAX;
        if (v < 16'(`PAC_DEC_MAX)) begin
            r = v[13:0];
        end
        return r;
    endfunction

    // --------------------------------------------------------------
    // wishbone slave: decode and answer
    // --------------------------------------------------------------
    pac_pkg::pac_rsp_t  rsp_q;
    pac_pkg::pac_rsp_t  rsp_d;
    logic [31:0]        rdat_q;
    logic [31:0]        rdat_d;
    logic [7:0]         idx;
    logic               req;
    logic               hit;
    logic               wr;
    logic [1:0][13:0]   acc_hi;
    logic [1:0][13:0]   acc_lo;
    logic [1:0][15:0]   freq;
    logic [8:0]         cd_q;
    logic [8:0]         cd_d;

    // byte address >> 2 is the implied register number
    assign idx = adr_i[9:2];
    assign req = cyc_i & stb_i & (rsp_q == pac_pkg::PAC_RSP_IDLE);

    always_comb begin
        hit = 1'b0;
        if (idx <= `PAC_IDX_AO_LAST) begin
            hit = 1'b1;
        end else if (IS_BASE && idx <= `PAC_IDX_LAST_BASE) begin
            hit = 1'b1;
        end else if (!IS_BASE && idx <= `PAC_IDX_LAST_EXP) begin
            hit = 1'b1;
        end
    end

    assign wr = req & hit & we_i;

    always_comb begin
        rsp_d  = pac_pkg::PAC_RSP_IDLE;
        rdat_d = rdat_q;
        if (req) begin
            // unimplemented address gets an error answer
            rsp_d  = hit ? pac_pkg::PAC_RSP_ACK
                         : pac_pkg::PAC_RSP_ERR;
            rdat_d = 32'h0000_0000;
            if (idx <= `PAC_IDX_AO_LAST) begin
                rdat_d = {16'h0000, ao_data_o[idx[2:0]]};
            end else if (IS_BASE) begin
                if (idx == `PAC_IDX_ACC_FIRST) begin
                    rdat_d = {18'h0_0000, acc_hi[0]};
                end else if (idx == `PAC_IDX_ACC_FIRST + 8'h01) begin
                    rdat_d = {18'h0_0000, acc_lo[0]};
                end else if (idx == `PAC_IDX_ACC_FIRST + 8'h02) begin
                    rdat_d = {18'h0_0000, acc_hi[1]};
                end else if (idx == `PAC_IDX_ACC_FIRST + 8'h03) begin
                    rdat_d = {18'h0_0000, acc_lo[1]};
                end else if (idx == `PAC_IDX_SAVE_CD) begin
                    rdat_d = {23'h00_0000, cd_q};
                end else if (idx == `PAC_IDX_FREQ_BASE) begin
                    rdat_d = {16'h0000, freq[0]};
                end else if (idx == `PAC_IDX_FREQ_BASE + 8'h01) begin
                    rdat_d = {16'h0000, freq[1]};
                end
            end else begin
                if (idx == `PAC_IDX_FREQ_EXP) begin
                    rdat_d = {16'h0000, freq[0]};
                end else if (idx == `PAC_IDX_FREQ_EXP + 8'h01) begin
                    rdat_d = {16'h0000, freq[1]};
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rsp_q  <= pac_pkg::PAC_RSP_IDLE;
            rdat_q <= 32'h0000_0000;
        end else begin
            rsp_q  <= rsp_d;
            rdat_q <= rdat_d;
        end
    end

    assign ack_o = (rsp_q == pac_pkg::PAC_RSP_ACK);
    assign err_o = (rsp_q == pac_pkg::PAC_RSP_ERR);
    assign dat_o = rdat_q;

    // --------------------------------------------------------------
    // analog output data words
    // --------------------------------------------------------------
    logic [7:0][15:0] ao_q;
    logic [7:0][15:0] ao_d;

    always_comb begin
        ao_d = ao_q;
        if (wr && idx <= `PAC_IDX_AO_LAST) begin
            ao_d[idx[2:0]] = pac_merge(ao_q[idx[2:0]], dat_i, sel_i);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ao_q <= {8{`PAC_AO_RST}};
        end else begin
            ao_q <= ao_d;
        end
    end

    assign ao_data_o = ao_q;

    // --------------------------------------------------------------
    // one-second timebase and save countdown
    // --------------------------------------------------------------
    logic [24:0] sec_q;
    logic [24:0] sec_d;
    logic        tick;
    logic        save_q;
    logic        save_d;

    assign tick = (sec_q == 25'(SEC_CYCLES - 1));

    always_comb begin
        sec_d  = tick ? 25'h000_0000 : sec_q + 25'h000_0001;
        cd_d   = cd_q;
        save_d = 1'b0;
        if (tick && IS_BASE) begin
            // zero stands for one second, then totals are saved
            if (cd_q == 9'h000) begin
                cd_d   = `PAC_SAVE_SECONDS;
                save_d = 1'b1;
            end else begin
                cd_d = cd_q - 9'h001;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sec_q  <= 25'h000_0000;
            cd_q   <= `PAC_SAVE_SECONDS;
            save_q <= 1'b0;
        end else begin
            sec_q  <= sec_d;
            cd_q   <= cd_d;
            save_q <= save_d;
        end
    end

    assign save_o = save_q;

    // --------------------------------------------------------------
    // per-input counting channels
    // --------------------------------------------------------------
    for (genvar i = 0; i < 2; i++) begin : g_ch
        localparam logic [7:0] HI_IDX = 8'(8 + 2 * i);
        localparam logic [7:0] LO_IDX = 8'(9 + 2 * i);

        logic [2:0]          smp_q;
        logic                rise;
        pac_pkg::pac_dec_t   hi_q, hi_d, lo_q, lo_d;
        pac_pkg::pac_dec_t   hi_b, lo_b;
        pac_pkg::pac_dec_t   shi_q, shi_d, slo_q, slo_d;
        pac_pkg::pac_word_t  fcnt_q, fcnt_d, freq_q, freq_d;

        // smp_q[0] feeds only smp_q[1]; edge seen on [1] vs [2]
        assign rise = smp_q[1] & ~smp_q[2];

        always_comb begin
            hi_b = hi_q;
            lo_b = lo_q;
            // a preset in the same cycle as a pulse still counts it
            if (wr && IS_BASE && idx == HI_IDX) begin
                hi_b = pac_clamp(pac_merge(16'(hi_q), dat_i, sel_i));
            end
            if (wr && IS_BASE && idx == LO_IDX) begin
                lo_b = pac_clamp(pac_merge(16'(lo_q), dat_i, sel_i));
            end
            hi_d = hi_b;
            lo_d = lo_b;
            if (rise && IS_BASE) begin
                if (lo_b >= `PAC_DEC_MAX) begin
                    lo_d = 14'h0000;
                    hi_d = (hi_b >= `PAC_DEC_MAX) ? 14'h0000
                                                  : hi_b + 14'h0001;
                end else begin
                    lo_d = lo_b + 14'h0001;
                end
            end
            shi_d = save_d ? hi_q : shi_q;
            slo_d = save_d ? lo_q : slo_q;
            // writes never reach freq_q: it only takes the gate count
            fcnt_d = fcnt_q;
            freq_d = freq_q;
            if (tick) begin
                freq_d = (rise && fcnt_q != `PAC_FREQ_MAX) ?
                         fcnt_q + 16'h0001 : fcnt_q;
                fcnt_d = 16'h0000;
            end else if (rise && fcnt_q != `PAC_FREQ_MAX) begin
                fcnt_d = fcnt_q + 16'h0001;
            end
        end

        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                smp_q  <= 3'h0;
                hi_q   <= `PAC_ACC_RST;
                lo_q   <= `PAC_ACC_RST;
                shi_q  <= `PAC_ACC_RST;
                slo_q  <= `PAC_ACC_RST;
                fcnt_q <= 16'h0000;
                freq_q <= 16'h0000;
            end else begin
                smp_q  <= {smp_q[1:0], cnt_in_i[i]};
                hi_q   <= hi_d;
                lo_q   <= lo_d;
                shi_q  <= shi_d;
                slo_q  <= slo_d;
                fcnt_q <= fcnt_d;
                freq_q <= freq_d;
            end
        end

        assign acc_hi[i]     = hi_q;
        assign acc_lo[i]     = lo_q;
        assign freq[i]       = freq_q;
        assign saved_hi_o[i] = shi_q;
        assign saved_lo_o[i] = slo_q;
    end

endmodule

`default_nettype wire

// >>> tb/pac_chk_sva.sv
`timescale 1ns/1ps
`include "pac_cfg.svh"
`default_nettype none

module pac_chk #(
    parameter bit IS_BASE    = 1'b1,
    parameter int SEC_CYCLES = `PAC_SEC_CYCLES
) (
    input wire logic             clk_i,
    input wire logic             rst_i,
    input wire logic [9:0]       adr_i,
    input wire logic [31:0]      dat_i,
    input wire logic [3:0]       sel_i,
    input wire logic             we_i,
    input wire logic             cyc_i,
    input wire logic             stb_i,
    input wire logic [31:0]      dat_o,
    input wire logic             ack_o,
    input wire logic             err_o,
    input wire logic [7:0][15:0] ao_data_o,
    input wire logic             save_o
);
    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    localparam logic [7:0] LAST =
        IS_BASE ? `PAC_IDX_LAST_BASE : `PAC_IDX_LAST_EXP;
    wire logic       req = cyc_i && stb_i && !ack_o && !err_o;
    wire logic [7:0] idx = adr_i[9:2];

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_answer;
        req |=> ack_o ^ err_o;
    endproperty
    a_answer: assert property (p_answer) else $error("no answer");
    property p_err_hit;
        req && idx > LAST |=> err_o;
    endproperty
    a_err_hit: assert property (p_err_hit) else $error("no err");
    property p_no_err;
        req && idx <= LAST |=> ack_o;
    endproperty
    a_no_err: assert property (p_no_err) else $error("bad err");
    property p_one_beat;
        ack_o || err_o |=> !(ack_o || err_o);
    endproperty
    a_one_beat: assert property (p_one_beat) else $error("long ack");
    property p_ao_write;
        req && we_i && sel_i == 4'hF && idx < 8'h08
        |=> ao_data_o[$past(adr_i[4:2])] == $past(dat_i[15:0]);
    endproperty
    a_ao_write: assert property (p_ao_write) else $error("ao lost");
    property p_err_keep;
        req && we_i && idx > LAST |=> $stable(ao_data_o);
    endproperty
    a_err_keep: assert property (p_err_keep) else $error("err wrote");
    property p_dec_max;
        req && !we_i && IS_BASE && idx >= 8'h08 && idx <= 8'h0B
        |=> dat_o <= {18'h0_0000, `PAC_DEC_MAX};
    endproperty
    a_dec_max: assert property (p_dec_max) else $error("over 9999");
    property p_hi_zero;
        ack_o |-> dat_o[31:16] == 16'h0000;
    endproperty
    a_hi_zero: assert property (p_hi_zero) else $error("upper set");
    // saves are minutes apart, so a repeat means a stuck strobe
    property p_save_gap;
        save_o |=> (!save_o) [*8];
    endproperty
    a_save_gap: assert property (p_save_gap) else $error("save rep");
endmodule

bind pac_counter pac_chk #(
    .IS_BASE    (IS_BASE),
    .SEC_CYCLES (SEC_CYCLES)
) i_pac_chk (
    .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i),
    .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
    .ao_data_o(ao_data_o), .save_o(save_o)
);

`default_nettype wire

// >>> tb/pac_meter.sv
`timescale 1ns/1ps
`default_nettype none

// meter pulse source: high one cycle, low one cycle, while go_i is high
module pac_meter (
    input  wire logic       clk_i,
    input  wire logic       go_i,
    input  wire logic [1:0] ch_i,
    output logic      [1:0] pulse_o
);
    logic ph_q = 1'b0;
    always_ff @(posedge clk_i) begin
        ph_q <= go_i && !ph_q;
    end
    assign pulse_o = ch_i & {2{ph_q}};
endmodule

`default_nettype wire

// >>> tb/test_pac_counter.sv
`timescale 1ns/1ps
`include "pac_cfg.svh"
`default_nettype none

module test_pac_counter;
    // ------------------------------------------------------------
    // stimulus and design
    // ------------------------------------------------------------
    logic               clk = 1'b0;
    logic               rst = 1'b1;
    logic [9:0]         adr = 10'h000;
    logic [31:0]        wd = 32'h0000_0000;
    logic [3:0]         sel = 4'h0;
    logic               we = 1'b0;
    logic [1:0]         cyc = 2'b00;
    logic               stb = 1'b0;
    logic               go = 1'b0;
    logic [1:0]         ch = 2'b00;
    wire logic [1:0]    pin, ack, err, save;
    wire logic [31:0]   rdat [2];
    wire logic [1:0][13:0] shi, slo;
    int                 mismatches = 0;
    int                 n_checks = 0;

    initial forever #20 clk = ~clk;

    pac_meter i_pac_meter (.clk_i(clk), .go_i(go), .ch_i(ch), .pulse_o(pin));
    pac_counter #(.IS_BASE(1'b1), .SEC_CYCLES(50)) i_pac_counter (
        .clk_i(clk), .rst_i(rst), .adr_i(adr), .dat_i(wd), .sel_i(sel),
        .we_i(we), .cyc_i(cyc[0]), .stb_i(stb), .dat_o(rdat[0]),
        .ack_o(ack[0]), .err_o(err[0]), .cnt_in_i(pin), .ao_data_o(),
        .save_o(save[0]), .saved_hi_o(shi), .saved_lo_o(slo));
    pac_counter #(.IS_BASE(1'b0), .SEC_CYCLES(50)) i_pac_counter_x (
        .clk_i(clk), .rst_i(rst), .adr_i(adr), .dat_i(wd), .sel_i(sel),
        .we_i(we), .cyc_i(cyc[1]), .stb_i(stb), .dat_o(rdat[1]),
        .ack_o(ack[1]), .err_o(err[1]), .cnt_in_i(pin), .ao_data_o(),
        .save_o(save[1]), .saved_hi_o(), .saved_lo_o());

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: %h vs %h", $time, seen, exp);
        end
    endtask

    // one classic cycle; r is {err, read word}
    task automatic bus(input logic u, input logic w, input logic [7:0] i,
                       input logic [15:0] d, input logic [3:0] s,
                       output logic [16:0] r);
        cyc <= u ? 2'b10 : 2'b01;
        stb <= 1'b1;
        we <= w;
        adr <= {i, 2'b00};
        wd <= {16'h0000, d};
        sel <= s;
        // no limit of its own: a hang is ended by the watchdog
        do begin
            @(posedge clk);
        end while (!(ack[u] || err[u]));
        r = {err[u], rdat[u][15:0]};
        cyc <= 2'b00;
        stb <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic u, input logic [7:0] i,
                      input logic [16:0] e);
        logic [16:0] r;
        bus(u, 1'b0, i, 16'h0000, 4'hF, r);
        chk({15'h0000, r}, {15'h0000, e});
    endtask

    task automatic wr(input logic u, input logic [7:0] i,
                      input logic [15:0] d, input logic e);
        logic [16:0] r;
        bus(u, 1'b1, i, d, 4'hF, r);
        chk({31'h0000_0000, r[16]}, {31'h0000_0000, e});
    endtask

    task automatic pulses(input logic [1:0] c, input int n);
        ch <= c;
        go <= 1'b1;
        repeat (2 * n) @(posedge clk);
        go <= 1'b0;
        repeat (4) @(posedge clk);
    endtask

    // a tick is seen as a change of the save countdown
    task automatic wait_tick;
        logic [16:0] a, b;
        int t;
        t = 0;
        bus(1'b0, 1'b0, `PAC_IDX_SAVE_CD, 16'h0000, 4'hF, a);
        do begin
            bus(1'b0, 1'b0, `PAC_IDX_SAVE_CD, 16'h0000, 4'hF, b);
            t++;
        end while (a === b && t < 40);
        if (a === b) begin
            mismatches++;
        end
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        logic [16:0] r;
        int t;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(1'b0, `PAC_IDX_SAVE_CD, 17'h0_012C);
        for (logic [7:0] i = 8'h08; i < 8'h0C; i++)
            rd(1'b0, i, 17'h0_0000);
        for (int u = 0; u < 2; u++) begin
            wr(u[0], 8'h07, 16'hA5C3, 1'b0);
            bus(u[0], 1'b1, 8'h07, 16'h1234, 4'h1, r);
            rd(u[0], 8'h07, 17'h0_A534);
        end
        wr(1'b0, 8'h0F, 16'h0001, 1'b1);
        rd(1'b0, 8'hFF, 17'h1_0000);
        rd(1'b1, 8'h0A, 17'h1_0000);
        wr(1'b1, 8'h08, 16'h5555, 1'b0);
        rd(1'b1, 8'h08, 17'h0_0000);
        wr(1'b0, 8'h09, 16'h270E, 1'b0);
        pulses(2'b01, 3);
        rd(1'b0, 8'h09, 17'h0_0001);
        rd(1'b0, 8'h08, 17'h0_0001);
        wr(1'b0, 8'h0A, 16'h270F, 1'b0);
        wr(1'b0, 8'h0B, 16'h270F, 1'b0);
        pulses(2'b10, 1);
        rd(1'b0, 8'h0A, 17'h0_0000);
        rd(1'b0, 8'h0B, 17'h0_0000);
        wait_tick();
        pulses(2'b11, 10);
        wait_tick();
        wr(1'b0, 8'h0D, 16'h0000, 1'b0);
        rd(1'b0, 8'h0D, 17'h0_000A);
        rd(1'b0, 8'h0E, 17'h0_000A);
        rd(1'b1, 8'h08, 17'h0_000A);
        rd(1'b1, 8'h09, 17'h0_000A);
        wr(1'b0, 8'h08, 16'h0012, 1'b0);
        wr(1'b0, 8'h09, 16'h0034, 1'b0);
        wr(1'b0, 8'h0A, 16'h1234, 1'b0);
        wr(1'b0, 8'h0B, 16'h0ABC, 1'b0);
        t = 0;
        while (save[0] !== 1'b1 && t < 20000) begin
            @(posedge clk);
            t++;
        end
        if (save[0] !== 1'b1) begin
            mismatches++;
        end
        chk({31'h0000_0000, save[1]}, 32'h0000_0000);
        @(posedge clk);
        chk({4'h0, shi[0], slo[0]}, {4'h0, 14'h0012, 14'h0034});
        chk({4'h0, shi[1], slo[1]}, {4'h0, 14'h1234, 14'h0ABC});
        rd(1'b0, `PAC_IDX_SAVE_CD, 17'h0_012C);
        print_verdict();
    end

    initial begin
        repeat (25000) @(posedge clk);
        mismatches++;
        print_verdict();
    end
endmodule

`default_nettype wire
